/* src/mac_multiply_unit.sv */
// Multiply datapath of the MAC coprocessor: decode, compute, flags
// Function
// - Four-byte instruction; first byte selects operand mode
// - Decode signed plain, rounded, negated codes
// - Decode mixed plain, rounded, negated codes
// - Decode rounded unsigned code in all modes
// - Signed product sign-extended, optional left shift
// - Negated signed: extend, shift, then negate
// - Mixed: limit kept, extension-used cleared
// - Rounded forms add constant, clear low word
// - Negated mixed: extend, negate, no shift
// - Unsigned rounded zero-extends; negative flag cleared
// - Overflow, carry cleared; sticky kept; zero tracks result
// - Negative flag follows result top bit, except unsigned rounded
// - Signed limit set only on shifted saturated minimum
// - Signed extension-used on shift, no saturation, minimum
// - Negated signed clears limit and extension-used
// - Unsigned rounded sets limit on saturation, extension-used
// - Extension-used means bits 39:31 are not all equal (value exceeds a signed 32-bit word)
`timescale 1ns/1ns
`default_nettype none
module mac_multiply_unit
    import mac_mul_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic issue_i,
    input wire logic [7:0] mode_byte_i,
    input wire logic [7:0] op_byte_i,
    input wire logic [15:0] operand_a_i,
    input wire logic [15:0] operand_b_i,
    input wire logic fractional_shift_mode_i,
    input wire logic saturation_mode_i,
    output logic [39:0] result_o,
    output logic done_o,
    output logic illegal_o,
    output logic overflow_flag_o,
    output logic limit_flag_o,
    output logic extension_used_flag_o,
    output logic sticky_overflow_flag_o,
    output logic carry_flag_o,
    output logic zero_result_flag_o,
    output logic negative_result_flag_o
);
    mul_if m ();
    mul_kind_e kind_w;
    logic mode_ok;
    logic op_ok;
    logic take;
    logic reject;
    logic neg_next;
    logic limit_next;
    logic ext_next;

    // Operand mode byte check; the pointer modes differ only in fetch
    assign mode_ok = (mode_byte_i == MODE_REG_REG) || (mode_byte_i == MODE_REG_IND)
        || (mode_byte_i == MODE_IDX_IND);
    // Operation byte decode
    assign op_ok = (op_byte_i == OP_SS) || (op_byte_i == OP_SS_RND) || (op_byte_i == OP_SS_NEG)
        || (op_byte_i == OP_SU) || (op_byte_i == OP_SU_RND) || (op_byte_i == OP_SU_NEG)
        || (op_byte_i == OP_UU_RND);
    assign kind_w = (op_byte_i == OP_SS_RND) ? K_SS_RND
        : (op_byte_i == OP_SS_NEG) ? K_SS_NEG
        : (op_byte_i == OP_SU) ? K_SU
        : (op_byte_i == OP_SU_RND) ? K_SU_RND
        : (op_byte_i == OP_SU_NEG) ? K_SU_NEG
        : (op_byte_i == OP_UU_RND) ? K_UU_RND
        : K_SS;
    assign take = clk_en_i && issue_i && mode_ok && op_ok;
    assign reject = clk_en_i && issue_i && !(mode_ok && op_ok);

    // Request to the arithmetic core
    assign m.kind = kind_w;
    assign m.op_a = operand_a_i;
    assign m.op_b = operand_b_i;
    assign m.frac = fractional_shift_mode_i;
    assign m.sat = saturation_mode_i;

    mul_arith_core u_core (
        .m(m.core)
    );

    // Flag next values per kind
    assign neg_next = (kind_w == K_UU_RND) ? 1'b0 : m.value[39];
    assign limit_next = (kind_w == K_SS_NEG) ? 1'b0
        : m.sat_hit ? 1'b1 : limit_flag_o;
    assign ext_next = m.ext_used;

    // Accumulator and flags; unknown opcodes leave state untouched
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            result_o <= RESULT_RST;
            overflow_flag_o <= FLAG_RST;
            limit_flag_o <= FLAG_RST;
            extension_used_flag_o <= FLAG_RST;
            carry_flag_o <= FLAG_RST;
            zero_result_flag_o <= FLAG_RST;
            negative_result_flag_o <= FLAG_RST;
        end
        else if (take)
        begin
            result_o <= m.value;
            overflow_flag_o <= 1'b0;
            carry_flag_o <= 1'b0;
            zero_result_flag_o <= (m.value == RESULT_RST);
            negative_result_flag_o <= neg_next;
            limit_flag_o <= limit_next;
            extension_used_flag_o <= ext_next;
        end
    end

    // Sticky overflow is never touched by a multiply
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            sticky_overflow_flag_o <= FLAG_RST;
        else if (take)
            sticky_overflow_flag_o <= sticky_overflow_flag_o;
    end

    // Completion and rejection strobes
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            done_o <= 1'b0;
            illegal_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            done_o <= take;
            illegal_o <= reject;
        end
    end

    property p_ovf_carry_clear;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        take |=> !overflow_flag_o && !carry_flag_o && done_o;
    endproperty
    a_ovf_carry_clear: assert property (p_ovf_carry_clear) else $error("overflow or carry not cleared");

    property p_sticky_kept;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        take |=> $stable(sticky_overflow_flag_o);
    endproperty
    a_sticky_kept: assert property (p_sticky_kept) else $error("sticky overflow changed");

    property p_zero_flag;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        done_o |-> zero_result_flag_o == (result_o == 40'h00_0000_0000);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag disagrees with result");

    property p_neg_flag;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        take && kind_w != K_UU_RND |=> negative_result_flag_o == result_o[39];
    endproperty
    a_neg_flag: assert property (p_neg_flag) else $error("negative flag not from top bit");

    property p_uu_neg_clear;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        take && kind_w == K_UU_RND |=> !negative_result_flag_o && result_o[15:0] == 16'h0000;
    endproperty
    a_uu_neg_clear: assert property (p_uu_neg_clear) else $error("unsigned rounded flags wrong");

    property p_mixed_limit;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        take && (kind_w == K_SU || kind_w == K_SU_RND || kind_w == K_SU_NEG)
        |=> $stable(limit_flag_o) && !extension_used_flag_o;
    endproperty
    a_mixed_limit: assert property (p_mixed_limit) else $error("mixed multiply flag error");

    property p_neg_ss_clear;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        take && kind_w == K_SS_NEG |=> !limit_flag_o && !extension_used_flag_o;
    endproperty
    a_neg_ss_clear: assert property (p_neg_ss_clear) else $error("negated signed flags not cleared");

    property p_ss_min_sat;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        take && kind_w == K_SS && fractional_shift_mode_i && saturation_mode_i
        && operand_a_i == 16'h8000 && operand_b_i == 16'h8000
        |=> limit_flag_o && result_o == 40'h00_7FFF_FFFF;
    endproperty
    a_ss_min_sat: assert property (p_ss_min_sat) else $error("signed minimum not saturated");

    property p_ss_ext;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        take && kind_w == K_SS |=> extension_used_flag_o == ($past(fractional_shift_mode_i)
        && !$past(saturation_mode_i) && $past(operand_a_i) == 16'h8000 && $past(operand_b_i) == 16'h8000);
    endproperty
    a_ss_ext: assert property (p_ss_ext) else $error("signed extension-used wrong");

    property p_reject_hold;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        reject |=> illegal_o && $stable(result_o);
    endproperty
    a_reject_hold: assert property (p_reject_hold) else $error("illegal opcode changed result");

    property p_rnd_low_clear;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        take && (kind_w == K_SS_RND || kind_w == K_SU_RND || kind_w == K_UU_RND) |=> result_o[15:0] == LOW_WORD_CLEAR;
    endproperty
    a_rnd_low_clear: assert property (p_rnd_low_clear) else $error("rounded low word not cleared");

    property p_ss_limit_kept;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        take && (kind_w == K_SS || kind_w == K_SS_RND) && !(fractional_shift_mode_i && saturation_mode_i)
        |=> $stable(limit_flag_o);
    endproperty
    a_ss_limit_kept: assert property (p_ss_limit_kept) else $error("signed limit flag changed");

    property p_uu_sat_limit;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        take && kind_w == K_UU_RND && saturation_mode_i && operand_a_i == 16'hFFFF && operand_b_i == 16'hFFFF
        |=> limit_flag_o && result_o == 40'h00_7FFF_0000;
    endproperty
    a_uu_sat_limit: assert property (p_uu_sat_limit) else $error("unsigned rounded not saturated");

    property p_uu_ext;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        take && kind_w == K_UU_RND && !saturation_mode_i && operand_a_i == 16'hFFFF && operand_b_i == 16'hFFFF
        |=> extension_used_flag_o && result_o == 40'h00_FFFE_0000;
    endproperty
    a_uu_ext: assert property (p_uu_ext) else $error("extension-used not set");
endmodule : mac_multiply_unit
`default_nettype wire

/* src/mac_mul_pkg.sv */
// Constants, opcode codes and helper functions for the multiply datapath
package mac_mul_pkg;
    // Operand mode byte (first opcode byte)
    localparam logic [7:0] MODE_REG_REG = 8'hA3;
    localparam logic [7:0] MODE_REG_IND = 8'h83;
    localparam logic [7:0] MODE_IDX_IND = 8'h93;
    // Operation byte (third opcode byte)
    localparam logic [7:0] OP_SS = 8'hC0;
    localparam logic [7:0] OP_SS_RND = 8'hC1;
    localparam logic [7:0] OP_SS_NEG = 8'hC8;
    localparam logic [7:0] OP_SU = 8'h40;
    localparam logic [7:0] OP_SU_RND = 8'h41;
    localparam logic [7:0] OP_SU_NEG = 8'h48;
    localparam logic [7:0] OP_UU_RND = 8'h01;
    // Instruction length in bytes
    localparam int INSTR_BYTES = 4;
    // Arithmetic constants
    localparam logic [39:0] ROUND_CONST = 40'h00_0000_8000;
    localparam logic [15:0] MOST_NEG = 16'h8000;
    localparam logic [39:0] SAT_POS = 40'h00_7FFF_FFFF;
    localparam logic [15:0] LOW_WORD_CLEAR = 16'h0000;
    // Reset values
    localparam logic [39:0] RESULT_RST = 40'h00_0000_0000;
    localparam logic FLAG_RST = 1'b0;

    typedef enum {
        K_SS,
        K_SS_RND,
        K_SS_NEG,
        K_SU,
        K_SU_RND,
        K_SU_NEG,
        K_UU_RND
    } mul_kind_e;

    // Result bits 39:31 are not a sign extension, so it exceeds a signed 32-bit word
    function automatic logic uses_ext(input logic [39:0] v);
        uses_ext = (v[39:31] != 9'h000) && (v[39:31] != 9'h1FF);
    endfunction : uses_ext

    // Both operands at the most negative value
    function automatic logic both_min(input logic [15:0] a, input logic [15:0] b);
        both_min = (a == MOST_NEG) && (b == MOST_NEG);
    endfunction : both_min
endpackage : mac_mul_pkg

/* src/mul_if.sv */
// Carrier between the multiply control and the arithmetic core
`timescale 1ns/1ns
`default_nettype none
interface mul_if;
    import mac_mul_pkg::*;
    mul_kind_e kind;
    logic [15:0] op_a;
    logic [15:0] op_b;
    logic frac;
    logic sat;
    logic [39:0] value;
    logic sat_hit;
    logic ext_used;

    modport ctrl (output kind, op_a, op_b, frac, sat, input value, sat_hit, ext_used);
    modport core (input kind, op_a, op_b, frac, sat, output value, sat_hit, ext_used);
endinterface : mul_if
`default_nettype wire

/* src/mul_arith_core.sv */
// Combinational product, shift, round, negate and saturate stage
`timescale 1ns/1ns
`default_nettype none
module mul_arith_core
    import mac_mul_pkg::*;
(
    mul_if.core m
);
    logic signed [31:0] prod_ss;
    logic signed [32:0] prod_su;
    logic [31:0] prod_uu;
    logic [39:0] ext_val;
    logic [39:0] shf_val;
    logic [39:0] rnd_val;
    logic [39:0] neg_val;
    logic [39:0] sat_val;
    logic is_ss;
    logic is_rnd;
    logic is_neg;
    logic min_pair;
    logic ss_sat;
    logic uu_sat;

    // Kind classification
    assign is_ss = (m.kind == K_SS) || (m.kind == K_SS_RND);
    assign is_rnd = (m.kind == K_SS_RND) || (m.kind == K_SU_RND) || (m.kind == K_UU_RND);
    assign is_neg = (m.kind == K_SS_NEG) || (m.kind == K_SU_NEG);
    assign min_pair = both_min(m.op_a, m.op_b);

    // Three product flavours; mixed keeps op_b unsigned by a zero top bit
    assign prod_ss = $signed({{16{m.op_a[15]}}, m.op_a}) * $signed({{16{m.op_b[15]}}, m.op_b});
    assign prod_su = $signed({{17{m.op_a[15]}}, m.op_a}) * $signed({{17{1'b0}}, m.op_b});
    assign prod_uu = {16'h0000, m.op_a} * {16'h0000, m.op_b};

    // Extension to 40 bits
    assign ext_val = (m.kind == K_UU_RND) ? {8'h00, prod_uu}
        : (m.kind == K_SU || m.kind == K_SU_RND || m.kind == K_SU_NEG)
        ? {{7{prod_su[32]}}, prod_su}
        : {{8{prod_ss[31]}}, prod_ss};

    // Fractional shift only for the signed family, never for mixed
    assign shf_val = ((m.kind == K_SS || m.kind == K_SS_RND || m.kind == K_SS_NEG) && m.frac)
        ? {ext_val[38:0], 1'b0} : ext_val;
    assign rnd_val = is_rnd ? 40'(shf_val + ROUND_CONST) : shf_val;
    assign neg_val = is_neg ? 40'(-rnd_val) : rnd_val;

    // Saturation only where the mode permits it
    assign ss_sat = is_ss && m.frac && m.sat && min_pair;
    assign uu_sat = (m.kind == K_UU_RND) && m.sat && uses_ext(neg_val);
    assign sat_val = (ss_sat || uu_sat) ? SAT_POS : neg_val;

    // Rounded forms clear the low word after saturation
    assign m.value = is_rnd ? {sat_val[39:16], LOW_WORD_CLEAR} : sat_val;
    assign m.sat_hit = ss_sat || uu_sat;
    assign m.ext_used = is_ss ? (m.frac && !m.sat && min_pair)
        : (m.kind == K_UU_RND) ? uses_ext(m.value) : 1'b0;
endmodule : mul_arith_core
`default_nettype wire

/* sim/core_model.sv */
// Behavioural processor core that issues multiply instructions
`timescale 1ns/1ns
`default_nettype none
module core_model
(
    output logic issue_o,
    output logic [7:0] mode_byte_o,
    output logic [7:0] op_byte_o,
    output logic [15:0] operand_a_o,
    output logic [15:0] operand_b_o,
    output logic frac_o,
    output logic sat_o
);
    // One instruction per call, launched just after a rising edge
    task automatic put(input logic [7:0] md, input logic [7:0] op, input logic [15:0] a, input logic [15:0] b,
        input logic fr, input logic st);
        issue_o <= 1'b1;
        mode_byte_o <= md;
        op_byte_o <= op;
        operand_a_o <= a;
        operand_b_o <= b;
        frac_o <= fr;
        sat_o <= st;
    endtask : put

    // Released operand lines show the inverse, so stale data cannot pass
    task automatic idle();
        issue_o <= 1'b0;
        operand_a_o <= ~operand_a_o;
        operand_b_o <= ~operand_b_o;
    endtask : idle

    // Quiet bus at time zero
    initial
    begin
        issue_o = 1'b0;
        mode_byte_o = 8'h00;
        op_byte_o = 8'h00;
        operand_a_o = 16'h0000;
        operand_b_o = 16'h0000;
        frac_o = 1'b0;
        sat_o = 1'b0;
    end
endmodule : core_model
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the multiply datapath
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import mac_mul_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic clk_en_i = 1'b1;
    wire logic issue, fr, st, done, illegal;
    wire logic [7:0] md, op;
    wire logic [15:0] a, b;
    wire logic [39:0] res;
    wire logic [6:0] fl;
    int fail_count = 0;
    int checked = 0;
    int seed = 32'h83c8_f3da;
    logic [7:0] ops [7] = '{8'hC0, 8'hC1, 8'hC8, 8'h40, 8'h41, 8'h48, 8'h01};
    logic [7:0] modes [3] = '{8'hA3, 8'h83, 8'h93};
    logic [46:0] exp_v, prev_v;
    logic exp_lim;
    logic [15:0] ra, rb;
    logic rf, rs;

    // Free-running 100 MHz clock
    always #5 core_clk_i = ~core_clk_i;

    core_model u_core (.issue_o(issue), .mode_byte_o(md), .op_byte_o(op), .operand_a_o(a),
        .operand_b_o(b), .frac_o(fr), .sat_o(st));
    mac_multiply_unit u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .issue_i(issue),
        .mode_byte_i(md), .op_byte_i(op), .operand_a_i(a), .operand_b_i(b), .fractional_shift_mode_i(fr),
        .saturation_mode_i(st), .result_o(res), .done_o(done), .illegal_o(illegal),
        .overflow_flag_o(fl[6]), .limit_flag_o(fl[5]), .extension_used_flag_o(fl[4]),
        .sticky_overflow_flag_o(fl[3]), .carry_flag_o(fl[2]), .zero_result_flag_o(fl[1]),
        .negative_result_flag_o(fl[0]));

    // Reference result: flags above the 40-bit accumulator value
    function automatic logic [46:0] model(input logic [7:0] c, input logic [15:0] x, input logic [15:0] y,
        input logic f, input logic s, input logic lo);
        logic [39:0] p;
        logic mn, lim, ext;
        mn = (x == 16'h8000) && (y == 16'h8000);
        lim = lo;
        ext = 1'b0;
        if (c[7])
            p = $signed(x) * $signed(y);
        else if (c[6])
            p = $signed(x) * $signed({1'b0, y});
        else
            p = x * y;
        if (c[7] && f)
            p = p << 1;
        if (c[0])
            p = p + 40'h00_0000_8000;
        if (c[7] && !c[3])
        begin
            ext = f && !s && mn;
            if (f && s && mn)
            begin
                p = 40'h00_7FFF_FFFF;
                lim = 1'b1;
            end
        end
        if (c == 8'h01 && s && p[39:31] != 9'h000)
        begin
            p = 40'h00_7FFF_FFFF;
            lim = 1'b1;
        end
        if (c[3])
            p = -p;
        if (c[3] && c[7])
            lim = 1'b0;
        if (c[0])
            p[15:0] = 16'h0000;
        if (c == 8'h01)
            ext = p[39:31] != 9'h000 && p[39:31] != 9'h1FF;
        return {1'b0, lim, ext, 2'b00, p == 40'h00_0000_0000, p[39] && c != 8'h01, p};
    endfunction : model

    task automatic check(input string name, input logic [46:0] seen, input logic [46:0] want);
        checked++;
        if (seen !== want)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, want, seen);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // Watchdog against a stuck run
    initial
    begin
        repeat (20000) @(posedge core_clk_i);
        fail_count++;
        test_done();
    end

    initial
    begin
        repeat (8) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        #1;
        check("reset", {fl, res}, 47'h0);
        exp_lim = 1'b0;
        // Back-to-back issue, every op, every mode, corners among random
        for (int i = 0; i <= 420; i++)
        begin
            @(posedge core_clk_i);
            ra = 16'($random(seed));
            rb = 16'($random(seed));
            rf = 1'($random(seed));
            rs = 1'($random(seed));
            if (i % 5 == 0)
            begin
                ra = 16'h8000;
                rb = 16'h8000;
                rf = 1'((i / 5) % 2);
                rs = 1'((i / 10) % 2);
            end
            if (i % 5 == 1)
                {ra, rb} = 32'hFFFF_FFFF;
            if (i % 5 == 2)
                ra = 16'h0000;
            if (i < 420)
                u_core.put(modes[i % 3], ops[i % 7], ra, rb, rf, rs);
            else
                u_core.idle();
            #1;
            if (i > 0)
            begin
                check("result", {fl, res}, prev_v);
                check("done", {45'h0, done, illegal}, 47'h2);
            end
            exp_v = model(ops[i % 7], ra, rb, rf, rs, exp_lim);
            // Only an issued instruction moves the kept limit flag
            if (i < 420)
            begin
                exp_lim = exp_v[45];
                prev_v = exp_v;
            end
        end
        // Unknown operation or mode byte leaves everything unchanged
        for (int k = 0; k < 2; k++)
        begin
            @(posedge core_clk_i);
            u_core.put(k ? 8'hD3 : 8'hA3, k ? 8'hC0 : 8'h90, 16'h0002, 16'h0003, 1'b0, 1'b0);
            @(posedge core_clk_i);
            u_core.idle();
            #1;
            check("illegal", {fl, res}, prev_v);
            check("illegal pulse", {45'h0, done, illegal}, 47'h1);
        end
        // Disabled clock ignores an issue
        @(posedge core_clk_i);
        clk_en_i <= 1'b0;
        u_core.put(8'hA3, 8'hC0, 16'h0002, 16'h0003, 1'b0, 1'b0);
        @(posedge core_clk_i);
        u_core.idle();
        @(posedge core_clk_i);
        clk_en_i <= 1'b1;
        #1;
        check("frozen", {fl, res}, prev_v);
        check("frozen strobes", {45'h0, done, illegal}, 47'h0);
        // Reset in mid-run clears the accumulator
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        u_core.put(8'hA3, 8'hC0, 16'h0002, 16'h0003, 1'b0, 1'b0);
        #1;
        check("reset again", {fl, res}, 47'h0);
        // First issue lands at the very first edge after release
        @(posedge core_clk_i);
        u_core.idle();
        #1;
        check("after reset", {fl, res}, model(8'hC0, 16'h0002, 16'h0003, 1'b0, 1'b0, 1'b0));
        check("after reset done", {45'h0, done, illegal}, 47'h2);
        test_done();
    end
endmodule : testbench
`default_nettype wire
